// [move_multiply_regs.vh]
// Field positions, encodings and step sizes for the move and multiply unit
`ifndef MOVE_MULTIPLY_REGS_VH
`define MOVE_MULTIPLY_REGS_VH

// Opcode fields
`define OP_TOP 15:12
`define OP_REG 11:9
`define OP_BIT8 8
`define OPERATION_SUBFIELD 8:6
`define OP_EA_MODE 5:3
`define OP_EA_REG 2:0
`define OP_DIR 10
`define OP_SIZE 6
`define OP_IMM 7:0
`define OP_MT_TOP 15:11
`define OP_MT_MID 9:7

// Opcode patterns
`define TOP_QUICK 4'h7
`define TOP_MUL 4'hC
`define TOP_PERIPH 4'h0
`define MT_TOP_VAL 5'h09
`define MT_MID_VAL 3'h1
`define MODE_SIGNED_MULTIPLY 3'h7
`define MODE_UNSIGNED_MULTIPLY 3'h3

// Peripheral operation subfield
`define PB_LOAD_W 3'h4
`define PB_LOAD_L 3'h5
`define PB_STORE_W 3'h6
`define PB_STORE_L 3'h7

// Addressing modes
`define EA_DREG 3'h0
`define EA_AREG 3'h1
`define EA_IND 3'h2
`define EA_POSTINC 3'h3
`define EA_PREDEC 3'h4
`define EA_DISP 3'h5
`define EA_INDEX 3'h6
`define EA_EXT 3'h7
`define EXT_ABS_W 3'h0
`define EXT_ABS_L 3'h1
`define EXT_PC_DISP 3'h2
`define EXT_PC_INDEX 3'h3
`define EXT_IMM 3'h4

// Mode check classes
`define CLS_STORE_MT 2'h0
`define CLS_LOAD_MT 2'h1
`define CLS_DATA 2'h2

// Condition code bit positions: X N Z V C
`define CC_X 4
`define CC_N 3
`define CC_Z 2
`define CC_V 1
`define CC_C 0

// Steps and counts
`define ADDR_STEP 32'h00000002
`define AREG_BASE 4'h8
`define MASK_END 5'h10
`define PB_WORD_BYTES 3'h2
`define PB_LONG_BYTES 3'h4

`endif

// [reg_bank.v]
// Sixteen data and address registers with registered read ports
`default_nettype none
module reg_bank #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter SEL_W = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Write port
  input wire we,
  input wire [SEL_W-1:0] wsel,
  input wire [WIDTH-1:0] wdata,
  // Read ports
  input wire [SEL_W-1:0] rsel_a,
  output reg [WIDTH-1:0] rdata_a,
  input wire [SEL_W-1:0] rsel_b,
  output reg [WIDTH-1:0] rdata_b
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem[wsel] <= wdata;
    end
  end

  // Reads see the old word when written in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      rdata_a <= {WIDTH{1'b0}};
      rdata_b <= {WIDTH{1'b0}};
    end else begin
      rdata_a <= mem[rsel_a];
      rdata_b <= mem[rsel_b];
    end
  end
endmodule
`default_nettype wire

// [ea_mode_check.v]
// Addressing mode legality for each instruction class
`include "move_multiply_regs.vh"
`default_nettype none
module ea_mode_check (
  // Mode fields
  input wire [2:0] mode,
  input wire [2:0] rsel,
  input wire [1:0] cls,
  // Verdict
  output reg legal
);
  always @* begin
    legal = 1'b0;
    case (cls)
      `CLS_STORE_MT: begin
        case (mode)
          `EA_IND, `EA_PREDEC, `EA_DISP, `EA_INDEX: legal = 1'b1;
          `EA_EXT: legal = (rsel == `EXT_ABS_W) || (rsel == `EXT_ABS_L);
          default: legal = 1'b0;
        endcase
      end
      `CLS_LOAD_MT: begin
        case (mode)
          `EA_IND, `EA_POSTINC, `EA_DISP, `EA_INDEX: legal = 1'b1;
          `EA_EXT: legal = (rsel <= `EXT_PC_INDEX);
          default: legal = 1'b0;
        endcase
      end
      `CLS_DATA: begin
        case (mode)
          `EA_AREG: legal = 1'b0;
          `EA_EXT: legal = (rsel <= `EXT_IMM);
          default: legal = 1'b1;
        endcase
      end
      default: legal = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [move_multiply_instr_exec.v]
// Execution unit for multi-register, peripheral, quick load and multiplies
// What this block does
// - Direction bit zero stores, one loads
// - Size bit picks word or long per register
// - Store transfer accepts non-PC control modes and predecrement
// - Load transfer accepts control, postincrement, PC modes
// - Mask low bit is first register moved
// - Predecrement reverses mask: bit 15 is D0
// - Predecrement stores downward, base holds last address
// - Postincrement loads upward, base gets last plus two
// - Loaded words are sign extended to 32
// - One extra read one word above last, none with predecrement
// - Peripheral bytes at every other address
// - Peripheral moves most significant byte first
// - Peripheral address is An plus displacement
// - Even address upper half, odd lower half
// - Decode peripheral operation subfield 100 to 111
// - Peripheral transfer leaves condition codes alone
// - Quick load sign extends low byte to Dn
// - Quick load is 0111 with bit 8 zero
// - Set N and Z, clear V C, keep X
// - Signed multiply of low words, 32-bit product
// - Unsigned multiply of low words, 32-bit product
// - Multiply register is destination, no An source
`include "move_multiply_regs.vh"
`default_nettype none
module move_multiply_instr_exec #(
  parameter ADDR_W = 32
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Instruction
  input wire start,
  input wire [15:0] opcode,
  input wire [15:0] ext_word,
  input wire [ADDR_W-1:0] ea_addr,
  input wire [31:0] src_operand,
  // Status
  output wire busy,
  output wire done,
  output reg illegal_q,
  output reg [4:0] ccr_q,
  // Register access while idle
  input wire reg_we,
  input wire [3:0] reg_sel,
  input wire [31:0] reg_wdata,
  output wire [31:0] reg_rdata,
  // Memory bus
  output wire mem_req,
  output wire mem_we,
  output reg [ADDR_W-1:0] mem_addr,
  output reg [15:0] mem_wdata,
  output wire mem_upper,
  output wire mem_lower,
  input wire [15:0] mem_rdata,
  input wire mem_ack
);
  localparam S_IDLE = 4'h0;
  localparam S_MUL = 4'h1;
  localparam S_PB_ADDR = 4'h2;
  localparam S_PB_DATA = 4'h3;
  localparam S_PB_BUS = 4'h4;
  localparam S_PB_WR = 4'h5;
  localparam S_MT_SCAN = 4'h6;
  localparam S_MT_RDW = 4'h7;
  localparam S_MT_BUS = 4'h8;
  localparam S_MT_WR = 4'h9;
  localparam S_MT_BASE = 4'hA;
  localparam S_MT_EXTRA = 4'hB;
  localparam S_DONE = 4'hC;

  reg [3:0] state_q;
  reg [15:0] op_q;
  reg [15:0] mask_q;
  reg [4:0] idx_q;
  reg [3:0] ridx_q;
  reg [ADDR_W-1:0] cur_q;
  reg [31:0] data_q;
  reg [31:0] acc_q;
  reg [31:0] src_q;
  reg [2:0] cnt_q;
  reg wcnt_q;

  // Decode of the live opcode
  wire [2:0] ea_mode = opcode[`OP_EA_MODE];
  wire [2:0] ea_reg = opcode[`OP_EA_REG];
  wire is_quick = (opcode[`OP_TOP] == `TOP_QUICK) &&
                  !opcode[`OP_BIT8];
  wire is_mul = (opcode[`OP_TOP] == `TOP_MUL) &&
                ((opcode[`OPERATION_SUBFIELD] == `MODE_SIGNED_MULTIPLY) ||
                 (opcode[`OPERATION_SUBFIELD] == `MODE_UNSIGNED_MULTIPLY));
  wire is_pb = (opcode[`OP_TOP] == `TOP_PERIPH) && opcode[`OP_BIT8] &&
               (ea_mode == `EA_AREG);
  wire is_mt = (opcode[`OP_MT_TOP] == `MT_TOP_VAL) &&
               (opcode[`OP_MT_MID] == `MT_MID_VAL);
  wire mt_load_in = opcode[`OP_DIR];
  reg [1:0] cls;
  wire mode_ok;

  always @* begin
    if (is_mul) begin
      cls = `CLS_DATA;
    end else if (mt_load_in) begin
      cls = `CLS_LOAD_MT;
    end else begin
      cls = `CLS_STORE_MT;
    end
  end

  ea_mode_check u_check (
    .mode(ea_mode),
    .rsel(ea_reg),
    .cls(cls),
    .legal(mode_ok)
  );

  // Fields of the held opcode
  wire mt_load = op_q[`OP_DIR];
  wire mt_long = op_q[`OP_SIZE];
  wire mt_predec = (op_q[`OP_EA_MODE] == `EA_PREDEC);
  wire mt_postinc = (op_q[`OP_EA_MODE] == `EA_POSTINC);
  wire [2:0] pb_op = op_q[`OPERATION_SUBFIELD];
  wire pb_load = (pb_op == `PB_LOAD_W) || (pb_op == `PB_LOAD_L);
  wire pb_long = (pb_op == `PB_LOAD_L) || (pb_op == `PB_STORE_L);
  wire [2:0] pb_bytes = pb_long ? `PB_LONG_BYTES : `PB_WORD_BYTES;
  wire [3:0] dreg = {1'b0, op_q[`OP_REG]};
  wire [3:0] areg = `AREG_BASE | {1'b0, op_q[`OP_EA_REG]};

  // Mask mapping differs for predecrement
  wire [3:0] mt_reg = mt_predec ? (4'hF - idx_q[3:0]) : idx_q[3:0];
  wire mt_last_word = (wcnt_q == mt_long);

  // Displacement sign, taken from the held extension word
  wire op_q_disp_sign = mask_q[15];

  // Register bank ports
  reg bank_we;
  reg [3:0] bank_wsel;
  reg [31:0] bank_wdata;
  reg [3:0] bank_rsel;
  wire [31:0] bank_rdata;

  // Products of the low words; upper words never reach the multiplier
  // Destination comes straight from the bank read launched at start
  wire signed [31:0] prod_s =
    $signed(src_q[15:0]) * $signed(bank_rdata[15:0]);
  wire [31:0] prod_u = src_q[15:0] * bank_rdata[15:0];
  wire [31:0] mul_res = (op_q[`OPERATION_SUBFIELD] == `MODE_SIGNED_MULTIPLY) ? prod_s : prod_u;
  wire [31:0] quick_res = {{24{opcode[7]}}, opcode[`OP_IMM]};

  reg_bank #(
    .WIDTH(32),
    .DEPTH(16),
    .SEL_W(4)
  ) u_bank (
    .clk(clk),
    .rst(rst),
    .we(bank_we),
    .wsel(bank_wsel),
    .wdata(bank_wdata),
    .rsel_a(bank_rsel),
    .rdata_a(bank_rdata),
    .rsel_b(reg_sel),
    .rdata_b(reg_rdata)
  );

  always @* begin
    bank_we = 1'b0;
    bank_wsel = reg_sel;
    bank_wdata = reg_wdata;
    bank_rsel = dreg;
    case (state_q)
      S_IDLE: begin
        if (start && is_quick) begin
          bank_we = 1'b1;
          bank_wsel = {1'b0, opcode[`OP_REG]};
          bank_wdata = quick_res;
        end else if (!start) begin
          bank_we = reg_we;
        end
        bank_rsel = is_pb ? (`AREG_BASE | {1'b0, ea_reg}) :
                    {1'b0, opcode[`OP_REG]};
      end
      S_MUL: begin
        bank_we = 1'b1;
        bank_wsel = dreg;
        bank_wdata = mul_res;
      end
      S_PB_ADDR: bank_rsel = dreg;
      S_PB_WR: begin
        bank_we = 1'b1;
        bank_wsel = dreg;
        bank_wdata = pb_long ? acc_q : {data_q[31:16], acc_q[15:0]};
      end
      S_MT_SCAN: bank_rsel = mt_reg;
      S_MT_WR: begin
        bank_we = 1'b1;
        bank_wsel = ridx_q;
        bank_wdata = mt_long ? acc_q :
                     {{16{acc_q[15]}}, acc_q[15:0]};
      end
      S_MT_BASE: begin
        bank_we = mt_predec || mt_postinc;
        bank_wsel = areg;
        bank_wdata = cur_q;
      end
      default: bank_we = 1'b0;
    endcase
  end

  // Memory bus drive
  wire in_pb = (state_q == S_PB_BUS);
  wire in_mt = (state_q == S_MT_BUS);
  assign mem_req = in_pb || in_mt || (state_q == S_MT_EXTRA);
  assign mem_we = (in_pb && !pb_load) || (in_mt && !mt_load);
  // Whole-word cycles use both halves
  assign mem_upper = in_pb ? !cur_q[0] : mem_req;
  assign mem_lower = in_pb ? cur_q[0] : mem_req;
  wire [7:0] pb_byte = pb_long ? data_q[31:24] : data_q[15:8];
  wire [15:0] mt_hi_sel = (wcnt_q != mt_predec) ? data_q[31:16] :
                          data_q[15:0];

  always @* begin
    mem_addr = cur_q;
    mem_wdata = {pb_byte, pb_byte};
    if (in_mt) begin
      mem_addr = mt_predec ? cur_q - `ADDR_STEP : cur_q;
      mem_wdata = mt_long ? mt_hi_sel : data_q[15:0];
    end
  end

  wire [7:0] rd_byte = cur_q[0] ? mem_rdata[7:0] : mem_rdata[15:8];

  assign busy = (state_q != S_IDLE);
  assign done = (state_q == S_DONE);

  always @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      op_q <= 16'h0000;
      mask_q <= 16'h0000;
      idx_q <= 5'h00;
      ridx_q <= 4'h0;
      cur_q <= {ADDR_W{1'b0}};
      data_q <= 32'h00000000;
      acc_q <= 32'h00000000;
      src_q <= 32'h00000000;
      cnt_q <= 3'h0;
      wcnt_q <= 1'b0;
      illegal_q <= 1'b0;
      ccr_q <= 5'h00;
    end else begin
      illegal_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start) begin
            op_q <= opcode;
            src_q <= src_operand;
            mask_q <= ext_word;
            idx_q <= 5'h00;
            cur_q <= ea_addr;
            acc_q <= 32'h00000000;
            if (is_quick) begin
              ccr_q[`CC_N] <= quick_res[31];
              ccr_q[`CC_Z] <= (quick_res == 32'h00000000);
              ccr_q[`CC_V] <= 1'b0;
              ccr_q[`CC_C] <= 1'b0;
              state_q <= S_DONE;
            end else if (is_mul && mode_ok) begin
              state_q <= S_MUL;
            end else if (is_pb) begin
              state_q <= S_PB_ADDR;
            end else if (is_mt && mode_ok) begin
              state_q <= S_MT_SCAN;
            end else begin
              illegal_q <= 1'b1;
            end
          end
        end
        S_MUL: begin
          ccr_q[`CC_N] <= mul_res[31];
          ccr_q[`CC_Z] <= (mul_res == 32'h00000000);
          ccr_q[`CC_V] <= 1'b0;
          ccr_q[`CC_C] <= 1'b0;
          state_q <= S_DONE;
        end
        S_PB_ADDR: begin
          cur_q <= bank_rdata + {{16{op_q_disp_sign}}, mask_q};
          cnt_q <= 3'h0;
          state_q <= S_PB_DATA;
        end
        S_PB_DATA: begin
          data_q <= bank_rdata;
          state_q <= S_PB_BUS;
        end
        S_PB_BUS: begin
          if (mem_ack) begin
            cur_q <= cur_q + `ADDR_STEP;
            // Loads keep the upper word intact for the final write
            if (!pb_load) begin
              data_q <= {data_q[23:0], 8'h00};
            end
            acc_q <= {acc_q[23:0], rd_byte};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q + 3'h1 == pb_bytes) begin
              state_q <= pb_load ? S_PB_WR : S_DONE;
            end
          end
        end
        S_PB_WR: begin
          // Condition codes untouched here
          state_q <= S_DONE;
        end
        S_MT_SCAN: begin
          wcnt_q <= 1'b0;
          ridx_q <= mt_reg;
          if (idx_q == `MASK_END) begin
            state_q <= S_MT_BASE;
          end else if (mask_q[idx_q[3:0]]) begin
            state_q <= mt_load ? S_MT_BUS : S_MT_RDW;
          end else begin
            idx_q <= idx_q + 5'h01;
          end
        end
        S_MT_RDW: begin
          data_q <= bank_rdata;
          state_q <= S_MT_BUS;
        end
        S_MT_BUS: begin
          if (mem_ack) begin
            cur_q <= mt_predec ? cur_q - `ADDR_STEP :
                     cur_q + `ADDR_STEP;
            acc_q <= {acc_q[15:0], mem_rdata};
            wcnt_q <= 1'b1;
            if (mt_last_word) begin
              if (mt_load) begin
                state_q <= S_MT_WR;
              end else begin
                idx_q <= idx_q + 5'h01;
                state_q <= S_MT_SCAN;
              end
            end
          end
        end
        S_MT_WR: begin
          idx_q <= idx_q + 5'h01;
          state_q <= S_MT_SCAN;
        end
        S_MT_BASE: begin
          // A trailing prefetch-style read, skipped when storing downward
          state_q <= mt_predec ? S_DONE : S_MT_EXTRA;
        end
        S_MT_EXTRA: begin
          if (mem_ack) begin
            state_q <= S_DONE;
          end
        end
        S_DONE: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [move_multiply_mem.sv]
// Memory and byte-wide peripheral model on the far side of the bus
`default_nettype none
module move_multiply_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus request
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_upper,
  input wire logic mem_lower,
  // Answer
  output var logic [15:0] mem_rdata,
  output var logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m [0:255];
  logic [34:0] log_q [$];
  logic [1:0] wt_q;
  logic [7:0] ev;
  logic [7:0] od;
  assign ev = {mem_addr[7:1], 1'b0};
  assign od = {mem_addr[7:1], 1'b1};
  initial mem_rdata = 16'h5A5A;
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    // Stale read data never looks valid
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      wt_q <= 2'h0;
    end else if (mem_req && !mem_ack) begin
      if (wt_q != 2'h0) begin
        wt_q <= wt_q - 2'h1;
      end else begin
        mem_ack <= 1'b1;
        // Mix prompt and slow answers
        wt_q <= 2'($urandom % 3);
        log_q.push_back({mem_we, mem_upper, mem_lower, mem_addr});
        if (!mem_we) begin
          mem_rdata <= {m[ev], m[od]};
        end else begin
          if (mem_upper) m[ev] <= mem_wdata[15:8];
          if (mem_lower) m[od] <= mem_wdata[7:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// [move_multiply_instr_exec_chk.sv]
// Port checker for the move and multiply unit
`default_nettype none
module move_multiply_instr_exec_chk #(
  parameter ADDR_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction and status
  input wire logic start,
  input wire logic [15:0] opcode,
  input wire logic busy,
  input wire logic done,
  input wire logic illegal_q,
  input wire logic [4:0] ccr_q,
  // Memory bus
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_upper,
  input wire logic mem_lower
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tk;
  logic one;
  logic pv_q;
  logic seen_q;
  logic [ADDR_W-1:0] pa_q;
  logic [15:0] op_q;
  logic [2:0] pc_q;
  assign tk = start && !busy;
  assign one = mem_upper ^ mem_lower;
  always @(posedge clk) begin
    seen_q <= mem_req && !mem_ack && !rst;
    if (tk) op_q <= opcode;
    if (rst || !busy) begin
      pv_q <= 1'b0;
      pc_q <= 3'h0;
    end else if (mem_req && mem_ack && one) begin
      pv_q <= 1'b1;
      pa_q <= mem_addr;
      pc_q <= pc_q + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_quick_flags: assert property (
    tk && opcode[15:12] == 4'h7 && !opcode[8] |=> done && ccr_q ==
    {$past(ccr_q[4]), $past(opcode[7]), $past(opcode[7:0]) == 8'h00, 2'h0})
    else $error("quick load flags wrong");
  a_mul_latency: assert property (
    tk && opcode[15:12] == 4'hC && opcode[7:3] == 5'h18
    |=> !done ##1 done) else $error("multiply latency wrong");
  a_mul_areg: assert property (
    tk && opcode[15:12] == 4'hC && opcode[7:3] == 5'h19
    |=> illegal_q && !done) else $error("address source accepted");
  a_mt_mode: assert property (
    tk && opcode[15:11] == 5'h09 && opcode[9:7] == 3'h1 &&
    opcode[5:3] == (opcode[10] ? 3'h4 : 3'h3) |=> illegal_q)
    else $error("bad transfer mode accepted");
  a_flag_update: assert property (
    ccr_q != $past(ccr_q) |-> ccr_q[1:0] == 2'h0 &&
    ccr_q[4] == $past(ccr_q[4])) else $error("flag update wrong");
  a_bus_keeps_ccr: assert property (
    mem_req |-> $stable(ccr_q)) else $error("flags moved during bus");
  a_lane_parity: assert property (
    mem_req |-> (mem_upper || mem_lower) &&
    (!one || mem_upper == !mem_addr[0])) else $error("lane wrong");
  a_byte_step: assert property (
    mem_req && !seen_q && one && pv_q |-> mem_addr == pa_q + 2)
    else $error("byte step wrong");
  a_byte_count: assert property (
    done && op_q[15:12] == 4'h0 && op_q[8] |->
    pc_q == (op_q[6] ? 3'h4 : 3'h2)) else $error("byte count wrong");
  c_quick: cover property (tk && opcode[15:12] == 4'h7);
  c_refused: cover property (illegal_q);
  c_byte: cover property (mem_req && mem_ack && one);
endmodule
`default_nettype wire

// [tb_move_multiply_instr_exec.sv]
// Testbench for the move and multiply unit
`default_nettype none
module tb_move_multiply_instr_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, start, reg_we, busy, done, illegal_q, mem_req, mem_we;
  logic mem_upper, mem_lower, mem_ack;
  logic [15:0] opcode, ext_word, mem_wdata, mem_rdata;
  logic [31:0] ea_addr, src_operand, reg_wdata, reg_rdata, mem_addr;
  logic [3:0] reg_sel;
  logic [4:0] ccr_q, cc;
  logic [4:0] exq [$];
  logic [7:0] d;
  logic [2:0] r;
  logic [31:0] a, b, p;
  logic [2:0] md [4] = '{3'h3, 3'h4, 3'h1, 3'h0};
  int errors, num_checks;
  move_multiply_instr_exec dut (.clk, .rst, .start, .opcode, .ext_word,
    .ea_addr, .src_operand, .busy, .done, .illegal_q, .ccr_q, .reg_we,
    .reg_sel, .reg_wdata, .reg_rdata, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_upper, .mem_lower, .mem_rdata, .mem_ack);
  move_multiply_mem mem (.clk, .rst, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_upper, .mem_lower, .mem_rdata, .mem_ack);
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [31:0] v);
    @(negedge clk);
    {reg_we, reg_sel, reg_wdata} = {1'b1, s, v};
    @(negedge clk);
    reg_we = 1'b0;
  endtask
  task automatic rd(input logic [3:0] s, input logic [31:0] e);
    @(negedge clk);
    reg_sel = s;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  // Illegal starts expect no done, so nothing is queued
  task automatic run(input logic [15:0] op, input logic [15:0] ext,
    input logic [31:0] ea, input logic bad);
    int n;
    if (!bad) exq.push_back(cc);
    mem.log_q.delete();
    @(negedge clk);
    {opcode, ext_word, ea_addr, start} = {op, ext, ea, 1'b1};
    @(negedge clk);
    start = 1'b0;
    n = 0;
    if (bad) chk(illegal_q, 1'b1);
    else while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) chk(done, 1'b1);
    @(negedge clk);
  endtask
  task automatic lanes(input int n, input logic [2:0] t,
    input logic [31:0] a0, input int st);
    chk(mem.log_q.size(), n);
    for (int k = 0; k < n && k < mem.log_q.size(); k++)
      chk(mem.log_q[k], {t, a0 + 32'(k * st)});
  endtask
  function automatic logic [31:0] sx(input logic [7:0] x);
    return {{16{mem.m[x][7]}}, mem.m[x], mem.m[x + 8'h01]};
  endfunction
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (exq.size() == 0) chk(done, 1'b0);
      else chk(ccr_q, exq.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    errors++;
    close_out();
  end
  initial begin
    {start, reg_we, opcode, ext_word, ea_addr, src_operand} = '0;
    {reg_sel, reg_wdata} = '0;
    rst = 1'b1;
    cc = 5'h00;
    void'($urandom(12));
    for (int i = 0; i < 256; i++) mem.m[i] = 8'($urandom);
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'($urandom);
      r = 3'(i);
      cc = {cc[4], d[7], d == 8'h00, 2'h0};
      run({4'h7, r, 1'b0, d}, 16'h0000, 32'h0, 1'b0);
      rd({1'b0, r}, {{24{d[7]}}, d});
    end
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 32'hFFFF0000 : $urandom;
      b = $urandom;
      r = 3'(i + 4);
      if (i[0]) p = $signed(a[15:0]) * $signed(b[15:0]);
      else p = a[15:0] * b[15:0];
      cc = {cc[4], p[31], p == 32'h0, 2'h0};
      wr({1'b0, r}, a);
      src_operand = b;
      run({4'hC, r, i[0] ? 3'h7 : 3'h3, 6'h00}, 16'h0, 32'h0, 1'b0);
      rd({1'b0, r}, p);
    end
    run({4'hC, 3'h1, 3'h7, 3'h1, 3'h2}, 16'h0, 32'h0, 1'b1);
    a = $urandom;
    wr(4'h9, 32'h31);
    wr(4'h2, a);
    run({4'h0, 3'h2, 3'h7, 3'h1, 3'h1}, 16'h0010, 32'h0, 1'b0);
    for (int k = 0; k < 4; k++)
      chk(mem.m[8'h41 + 8'(2 * k)], a[31 - 8 * k -: 8]);
    lanes(4, 3'h5, 32'h41, 2);
    b = $urandom;
    wr(4'h3, b);
    run({4'h0, 3'h3, 3'h4, 3'h1, 3'h1}, 16'h001F, 32'h0, 1'b0);
    rd(4'h3, {b[31:16], mem.m[8'h50], mem.m[8'h52]});
    lanes(2, 3'h2, 32'h50, 2);
    wr(4'h8, 32'h80);
    run({5'h09, 1'b1, 3'h1, 1'b0, 3'h3, 3'h0}, 16'h0403, 32'h80, 1'b0);
    rd(4'h0, sx(8'h80));
    rd(4'h1, sx(8'h82));
    rd(4'hA, sx(8'h84));
    rd(4'h8, 32'h86);
    lanes(4, 3'h3, 32'h80, 2);
    wr(4'h0, a);
    wr(4'hF, b);
    wr(4'h9, 32'hC0);
    run({5'h09, 1'b0, 3'h1, 1'b0, 3'h4, 3'h1}, 16'h8001, 32'hC0, 1'b0);
    chk({mem.m[8'hBE], mem.m[8'hBF]}, b[15:0]);
    chk({mem.m[8'hBC], mem.m[8'hBD]}, a[15:0]);
    rd(4'h9, 32'hBC);
    lanes(2, 3'h7, 32'hBE, -2);
    for (int k = 0; k < 4; k++)
      run({5'h09, k[0], 3'h1, 1'b0, md[k], 3'h0}, 16'h1, 32'h0, 1'b1);
    close_out();
  end
endmodule
bind move_multiply_instr_exec move_multiply_instr_exec_chk #(
  .ADDR_W(ADDR_W)) chk_i (.clk, .rst, .start, .opcode, .busy, .done,
  .illegal_q, .ccr_q, .mem_req, .mem_ack, .mem_addr, .mem_upper,
  .mem_lower);
`default_nettype wire
